// ===== hdl/link_rate_negotiation.sv
// Rate matching and PHY configuration handshake of a link training port
//
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/10ps
module link_rate_negotiation #(
   parameter int TIMEOUT_CYC = link_rate_negotiation_pkg::TIMEOUT_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Link state machine
   input wire logic enter_first_i,
   input wire logic enter_retry_i,
   input wire logic warm_reset_det_i,
   output logic exit_valid_o,
   output logic [2:0] exit_code_o,
   output logic busy_o,
   // Message transceiver
   output logic [7:0] tx_msg_o,
   output logic tx_send_o,
   input wire logic tx_done_i,
   input wire logic [7:0] rx_msg_i,
   input wire logic rx_valid_i,
   // PHY control
   output logic phy_reconfig_o,
   output logic [1:0] phy_rate_o,
   input wire logic phy_done_i,
   output logic tx_elec_idle_o,
   output logic rx_term_o,
   output logic tseq_prep_o
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic msg_matches(input logic [7:0] msg, input logic [1:0] mtype,
                                        input logic [1:0] rate);
      msg_matches = (msg[1:0] == mtype) && (msg[3:2] == rate);
   endfunction : msg_matches

   function automatic logic [7:0] build_msg(input logic [1:0] mtype, input logic [1:0] rate);
      build_msg = {link_rate_negotiation_pkg::MSG_RSVD, rate, mtype};
   endfunction : build_msg

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   link_rate_negotiation_pkg::state_t state_reg;
   link_rate_negotiation_pkg::state_t state_next;
   logic [1:0] role_reg;
   logic [1:0] max_rate_reg;
   logic [1:0] poll_cnt_reg;
   logic early_ready_reg;
   logic disable_cmd_reg;
   logic warm_cmd_reg;
   logic [1:0] cap_reg;
   logic [1:0] phy_rate_reg;
   logic [1:0] rx_cnt_reg;
   logic [2:0] tx_cnt_reg;
   logic [link_rate_negotiation_pkg::TIMER_W-1:0] timer_reg;
   logic timer_run_reg;
   logic [7:0] last_rx_reg;
   logic [2:0] last_exit_reg;
   logic wb_req;
   logic wb_wr;
   logic active;
   logic expired;
   logic kill_disable;
   logic kill_warm;
   logic handshake_done;
   logic [2:0] exit_next;
   logic [1:0] rx_type;
   logic [1:0] rx_rate;
   logic lower_req;

   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wb_wr = wb_req && wb_we_i;
   assign active = (state_reg != link_rate_negotiation_pkg::ST_IDLE);
   assign rx_type = rx_msg_i[1:0];
   assign rx_rate = rx_msg_i[3:2];
   // Partner asks for a lower rate; only capability or ready types count
   assign lower_req = (state_reg == link_rate_negotiation_pkg::ST_MATCH) && rx_valid_i &&
                      (rx_type == link_rate_negotiation_pkg::TYPE_CAP ||
                       rx_type == link_rate_negotiation_pkg::TYPE_READY) &&
                      (rx_rate < cap_reg);
   assign expired = timer_run_reg &&
                    (timer_reg >= link_rate_negotiation_pkg::TIMER_W'(TIMEOUT_CYC - 1));
   assign kill_disable = disable_cmd_reg &&
                         (role_reg == link_rate_negotiation_pkg::ROLE_DOWN);
   assign kill_warm = (warm_cmd_reg && (role_reg == link_rate_negotiation_pkg::ROLE_DOWN)) ||
                      (warm_reset_det_i &&
                       (role_reg != link_rate_negotiation_pkg::ROLE_DOWN));
   assign handshake_done = tx_done_i && (rx_cnt_reg == link_rate_negotiation_pkg::RX_NEEDED) &&
                           (tx_cnt_reg == link_rate_negotiation_pkg::TX_NEEDED - 3'h1);

   // ----------------------------------------------------------------
   // Wishbone slave
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= wb_req;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_dat_o <= 32'h0;
      else if (wb_req && !wb_we_i)
      begin
         unique case (wb_adr_i)
            link_rate_negotiation_pkg::CTRL_ADDR:
               wb_dat_o <= {25'h0, early_ready_reg, poll_cnt_reg, max_rate_reg, role_reg};
            link_rate_negotiation_pkg::STATUS_ADDR:
               wb_dat_o <= {16'h0, 1'b0, last_exit_reg, 1'b0, tx_cnt_reg, 2'h0, rx_cnt_reg,
                            cap_reg, 2'(state_reg)};
            link_rate_negotiation_pkg::MSG_ADDR:
               wb_dat_o <= {16'h0, tx_msg_o, last_rx_reg};
            link_rate_negotiation_pkg::PHY_ADDR:
               wb_dat_o <= {30'h0, phy_rate_reg};
            default:
               wb_dat_o <= 32'h0;
         endcase
      end
   end

   // Control fields steer role, supported rate and optional early ready
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         role_reg <= link_rate_negotiation_pkg::ROLE_RESET;
         max_rate_reg <= link_rate_negotiation_pkg::MAX_RESET;
         poll_cnt_reg <= 2'h0;
         early_ready_reg <= 1'b0;
      end
      else if (wb_wr && wb_adr_i == link_rate_negotiation_pkg::CTRL_ADDR && wb_sel_i[0])
      begin
         role_reg <= wb_dat_i[link_rate_negotiation_pkg::CTRL_ROLE_LSB +: 2];
         max_rate_reg <= wb_dat_i[link_rate_negotiation_pkg::CTRL_MAX_LSB +: 2];
         poll_cnt_reg <= wb_dat_i[link_rate_negotiation_pkg::CTRL_POLL_LSB +: 2];
         early_ready_reg <= wb_dat_i[link_rate_negotiation_pkg::CTRL_EARLY_BIT];
      end
   end

   // Directed disable and warm reset are one-cycle commands
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         disable_cmd_reg <= 1'b0;
         warm_cmd_reg <= 1'b0;
      end
      else
      begin
         disable_cmd_reg <= wb_wr && wb_adr_i == link_rate_negotiation_pkg::CTRL_ADDR &&
                            wb_sel_i[1] && wb_dat_i[link_rate_negotiation_pkg::CTRL_DISABLE_BIT];
         warm_cmd_reg <= wb_wr && wb_adr_i == link_rate_negotiation_pkg::CTRL_ADDR &&
                         wb_sel_i[1] && wb_dat_i[link_rate_negotiation_pkg::CTRL_WARM_BIT];
      end
   end

   // Current PHY rate; the hardware updates it when reconfiguration ends
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         phy_rate_reg <= link_rate_negotiation_pkg::PHY_RATE_RESET;
      else if (state_reg == link_rate_negotiation_pkg::ST_RECONF && phy_done_i)
         phy_rate_reg <= cap_reg;
      else if (wb_wr && wb_adr_i == link_rate_negotiation_pkg::PHY_ADDR && wb_sel_i[0] && !active)
         phy_rate_reg <= wb_dat_i[1:0];
   end

   // ----------------------------------------------------------------
   // Exit selection
   // ----------------------------------------------------------------
   always_comb
   begin
      exit_next = link_rate_negotiation_pkg::EXIT_NONE;
      if (kill_disable)
         exit_next = link_rate_negotiation_pkg::EXIT_DISABLED;
      else if (kill_warm)
         exit_next = link_rate_negotiation_pkg::EXIT_RX_DETECT;
      else if (expired)
      begin
         unique case (role_reg)
            link_rate_negotiation_pkg::ROLE_DOWN:
               exit_next = (poll_cnt_reg < link_rate_negotiation_pkg::POLL_CNT_LIMIT) ?
                           link_rate_negotiation_pkg::EXIT_RX_DETECT :
                           link_rate_negotiation_pkg::EXIT_INACTIVE;
            link_rate_negotiation_pkg::ROLE_HUB_UP:
               exit_next = link_rate_negotiation_pkg::EXIT_RX_DETECT;
            default:
               exit_next = link_rate_negotiation_pkg::EXIT_DISABLED;
         endcase
      end
      else if (state_reg == link_rate_negotiation_pkg::ST_READY && handshake_done)
         exit_next = link_rate_negotiation_pkg::EXIT_RXEQ;
   end

   // ----------------------------------------------------------------
   // State machine
   // ----------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         link_rate_negotiation_pkg::ST_IDLE:
            if (enter_first_i || enter_retry_i)
               state_next = link_rate_negotiation_pkg::ST_MATCH;
         link_rate_negotiation_pkg::ST_MATCH:
            if (handshake_done && !lower_req)
            begin
               if (cap_reg == phy_rate_reg && early_ready_reg)
                  state_next = link_rate_negotiation_pkg::ST_READY;
               else
                  state_next = link_rate_negotiation_pkg::ST_RECONF;
            end
         link_rate_negotiation_pkg::ST_RECONF:
            if (phy_done_i)
               state_next = link_rate_negotiation_pkg::ST_READY;
         link_rate_negotiation_pkg::ST_READY:
            state_next = state_reg;
      endcase
      if (active && exit_next != link_rate_negotiation_pkg::EXIT_NONE)
         state_next = link_rate_negotiation_pkg::ST_IDLE;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         state_reg <= link_rate_negotiation_pkg::ST_IDLE;
      else
         state_reg <= state_next;
   end

   // ----------------------------------------------------------------
   // Timeout timer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         timer_reg <= '0;
         timer_run_reg <= 1'b0;
      end
      else if (state_reg == link_rate_negotiation_pkg::ST_IDLE &&
               state_next == link_rate_negotiation_pkg::ST_MATCH)
      begin
         timer_reg <= '0;
         timer_run_reg <= 1'b1;
      end
      else if (state_next == link_rate_negotiation_pkg::ST_IDLE)
      begin
         timer_reg <= '0;
         timer_run_reg <= 1'b0;
      end
      else if (timer_run_reg)
         timer_reg <= timer_reg + 1'b1;
   end

   // ----------------------------------------------------------------
   // Announced capability
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         cap_reg <= link_rate_negotiation_pkg::MAX_RESET;
      else if (state_reg == link_rate_negotiation_pkg::ST_IDLE)
      begin
         if (enter_first_i)
            cap_reg <= max_rate_reg;
         else if (enter_retry_i && cap_reg != link_rate_negotiation_pkg::RATE_5G)
            cap_reg <= cap_reg - 2'h1;
      end
      else if (lower_req)
         cap_reg <= rx_rate;
   end

   // ----------------------------------------------------------------
   // Consecutive receive and send counters
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         rx_cnt_reg <= 2'h0;
      else if (state_next != state_reg)
         rx_cnt_reg <= 2'h0;
      else if (rx_valid_i && state_reg == link_rate_negotiation_pkg::ST_MATCH)
      begin
         if (msg_matches(rx_msg_i, link_rate_negotiation_pkg::TYPE_CAP, cap_reg) ||
             msg_matches(rx_msg_i, link_rate_negotiation_pkg::TYPE_READY, cap_reg))
         begin
            if (rx_cnt_reg != link_rate_negotiation_pkg::RX_NEEDED)
               rx_cnt_reg <= rx_cnt_reg + 2'h1;
         end
         else
            rx_cnt_reg <= 2'h0;
      end
      else if (rx_valid_i && state_reg == link_rate_negotiation_pkg::ST_READY)
      begin
         if (msg_matches(rx_msg_i, link_rate_negotiation_pkg::TYPE_READY,
                         link_rate_negotiation_pkg::RATE_5G))
         begin
            if (rx_cnt_reg != link_rate_negotiation_pkg::RX_NEEDED)
               rx_cnt_reg <= rx_cnt_reg + 2'h1;
         end
         else
            rx_cnt_reg <= 2'h0;
      end
   end

   // Sends count only once two matched messages have arrived
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         tx_cnt_reg <= 3'h0;
      else if (state_next != state_reg)
         tx_cnt_reg <= 3'h0;
      else if (lower_req)
         tx_cnt_reg <= 3'h0;
      else if (tx_done_i && tx_send_o &&
               rx_cnt_reg == link_rate_negotiation_pkg::RX_NEEDED)
         tx_cnt_reg <= tx_cnt_reg + 3'h1;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         last_rx_reg <= 8'h0;
      else if (rx_valid_i)
         last_rx_reg <= rx_msg_i;
   end

   // ----------------------------------------------------------------
   // Exit report
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         exit_valid_o <= 1'b0;
         exit_code_o <= link_rate_negotiation_pkg::EXIT_NONE;
         last_exit_reg <= link_rate_negotiation_pkg::EXIT_NONE;
      end
      else
      begin
         exit_valid_o <= active && exit_next != link_rate_negotiation_pkg::EXIT_NONE;
         if (active && exit_next != link_rate_negotiation_pkg::EXIT_NONE)
         begin
            exit_code_o <= exit_next;
            last_exit_reg <= exit_next;
         end
      end
   end

   // ----------------------------------------------------------------
   // Transmit and PHY outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tx_msg_o <= 8'h0;
         tx_send_o <= 1'b0;
      end
      else
      begin
         unique case (state_next)
            link_rate_negotiation_pkg::ST_MATCH:
            begin
               tx_msg_o <= build_msg(link_rate_negotiation_pkg::TYPE_CAP,
                                     lower_req ? rx_rate :
                                     (state_reg == link_rate_negotiation_pkg::ST_MATCH ?
                                      cap_reg :
                                      (enter_first_i ? max_rate_reg :
                                       (cap_reg != link_rate_negotiation_pkg::RATE_5G ?
                                        cap_reg - 2'h1 : cap_reg))));
               tx_send_o <= 1'b1;
            end
            link_rate_negotiation_pkg::ST_READY:
            begin
               tx_msg_o <= build_msg(link_rate_negotiation_pkg::TYPE_READY,
                                     link_rate_negotiation_pkg::RATE_5G);
               tx_send_o <= 1'b1;
            end
            default:
            begin
               tx_msg_o <= tx_msg_o;
               tx_send_o <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         phy_reconfig_o <= 1'b0;
         tx_elec_idle_o <= 1'b1;
         rx_term_o <= 1'b0;
         tseq_prep_o <= 1'b0;
         busy_o <= 1'b0;
      end
      else
      begin
         phy_reconfig_o <= (state_next == link_rate_negotiation_pkg::ST_RECONF);
         tx_elec_idle_o <= (state_next != link_rate_negotiation_pkg::ST_MATCH &&
                            state_next != link_rate_negotiation_pkg::ST_READY);
         rx_term_o <= (state_next != link_rate_negotiation_pkg::ST_IDLE);
         tseq_prep_o <= (state_next == link_rate_negotiation_pkg::ST_RECONF ||
                         state_next == link_rate_negotiation_pkg::ST_READY);
         busy_o <= (state_next != link_rate_negotiation_pkg::ST_IDLE);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         phy_rate_o <= link_rate_negotiation_pkg::PHY_RATE_RESET;
      else if (state_next == link_rate_negotiation_pkg::ST_RECONF)
         phy_rate_o <= cap_reg;
      else
         phy_rate_o <= phy_rate_reg;
   end

endmodule : link_rate_negotiation

// ===== inc/link_rate_negotiation_pkg.sv
// Constants and types shared by the link rate negotiation logic
package link_rate_negotiation_pkg;

   // -----------------------------------------------------------------
   // Message layout
   // -----------------------------------------------------------------
   localparam int MSG_W = 8;
   localparam int RATE_W = 2;
   localparam logic [1:0] TYPE_CAP = 2'h0;
   localparam logic [1:0] TYPE_READY = 2'h1;
   localparam logic [1:0] RATE_5G = 2'h0;
   localparam logic [1:0] RATE_10G = 2'h1;
   localparam logic [3:0] MSG_RSVD = 4'h0;

   // -----------------------------------------------------------------
   // Handshake counts and timing
   // -----------------------------------------------------------------
   localparam logic [1:0] RX_NEEDED = 2'h2;
   localparam logic [2:0] TX_NEEDED = 3'h4;
   localparam logic [1:0] POLL_CNT_LIMIT = 2'h2;
   localparam int CLK_HZ = 20000000;
   localparam int TIMEOUT_MS = 12;
   localparam int TIMEOUT_CYCLES = (CLK_HZ / 1000) * TIMEOUT_MS;
   localparam int TIMER_W = 18;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam logic [7:0] MSG_ADDR = 8'h08;
   localparam logic [7:0] PHY_ADDR = 8'h0c;
   localparam int CTRL_ROLE_LSB = 0;
   localparam int CTRL_MAX_LSB = 2;
   localparam int CTRL_POLL_LSB = 4;
   localparam int CTRL_EARLY_BIT = 6;
   localparam int CTRL_DISABLE_BIT = 8;
   localparam int CTRL_WARM_BIT = 9;
   localparam logic [1:0] ROLE_RESET = 2'h0;
   localparam logic [1:0] MAX_RESET = 2'h1;
   localparam logic [1:0] PHY_RATE_RESET = 2'h1;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {ROLE_DOWN, ROLE_HUB_UP, ROLE_PERIPH, ROLE_SPARE} role_t;
   typedef enum logic [2:0] {EXIT_NONE, EXIT_RXEQ, EXIT_RX_DETECT, EXIT_INACTIVE,
                             EXIT_DISABLED} exit_t;
   typedef enum {ST_IDLE, ST_MATCH, ST_RECONF, ST_READY} state_t;

endpackage : link_rate_negotiation_pkg

// ===== verification/link_partner_model.sv
// Behavioural model of the link partner's negotiation logic
`timescale 1ns/10ps
module link_partner_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bench control
   input wire logic [1:0] cap_i,
   input wire logic mute_i,
   input wire logic slow_i,
   // Message transceiver
   input wire logic [7:0] tx_msg_i,
   input wire logic tx_send_i,
   output logic tx_done_o,
   output logic [7:0] rx_msg_o,
   output logic rx_valid_o
);
   logic [2:0] tick_reg;
   logic [1:0] cap_reg;
   logic [1:0] low;

   assign low = (tx_msg_i[3:2] < cap_reg) ? tx_msg_i[3:2] : cap_reg;

   // One message each way per send period; stale data is scrambled
   always_ff @(posedge clk_i)
   begin
      tx_done_o <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_msg_o <= ~rx_msg_o;
      tick_reg <= tick_reg + 3'h1;
      if (rst_i || !tx_send_i)
      begin
         tick_reg <= 3'h0;
         cap_reg <= cap_i;
         if (rst_i)
            rx_msg_o <= 8'h00;
      end
      else if (tick_reg == (slow_i ? 3'h6 : 3'h2))
      begin
         tick_reg <= 3'h0;
         tx_done_o <= 1'b1;
         rx_valid_o <= !mute_i;
         cap_reg <= low;
         if (tx_msg_i[1:0] == link_rate_negotiation_pkg::TYPE_READY)
            rx_msg_o <= 8'h01;
         else
            rx_msg_o <= {4'h0, low, 2'h0};
      end
   end
endmodule : link_partner_model

// ===== verification/link_rate_negotiation_props.sv
// Port-level concurrent checks for the rate negotiation block
`timescale 1ns/10ps
module link_rate_negotiation_props #(
   parameter int TIMEOUT_CYC = 200
) (
   // Clock, reset and bus
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // Link side
   input wire logic enter_first_i,
   input wire logic enter_retry_i,
   input wire logic exit_valid_o,
   input wire logic [2:0] exit_code_o,
   input wire logic busy_o,
   input wire logic [7:0] tx_msg_o,
   input wire logic tx_send_o,
   // PHY side
   input wire logic phy_reconfig_o,
   input wire logic tx_elec_idle_o,
   input wire logic rx_term_o,
   input wire logic tseq_prep_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   int busy_cnt;

   // Cycles spent since the handshake started
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !busy_o)
         busy_cnt <= 0;
      else
         busy_cnt <= busy_cnt + 1;
   end

   a_msg_rsvd_zero: assert property (tx_send_o |-> tx_msg_o[7:4] == 4'h0)
      else $error("reserved message bits not zero");
   a_ready_rate_zero: assert property (tx_send_o && tx_msg_o[1:0] == 2'h1
      |-> tx_msg_o[3:2] == 2'h0) else $error("ready message carries a rate");
   a_entry_announce: assert property (!busy_o && (enter_first_i || enter_retry_i)
      |=> busy_o && tx_send_o && tx_msg_o[1:0] == 2'h0) else $error("entry did not announce");
   a_reconf_quiet: assert property (phy_reconfig_o |-> tx_elec_idle_o && !tx_send_o)
      else $error("transmitter active while reconfiguring");
   a_reconf_prep: assert property (phy_reconfig_o |-> rx_term_o && tseq_prep_o)
      else $error("termination or equalization prep missing");
   a_timer_bound: assert property (busy_cnt <= TIMEOUT_CYC + 1)
      else $error("handshake outlived its timeout");
   a_exit_after_ready: assert property (exit_valid_o && exit_code_o == 3'h1
      |-> $past(tx_msg_o) == 8'h01 && $past(busy_o)) else $error("success without ready");
   a_exit_pulse: assert property (exit_valid_o |-> !busy_o ##1 !exit_valid_o)
      else $error("exit strobe malformed");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered in one cycle");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
endmodule : link_rate_negotiation_props

bind link_rate_negotiation link_rate_negotiation_props #(.TIMEOUT_CYC(TIMEOUT_CYC))
   chk (.*);

// ===== verification/link_rate_negotiation_test.sv
// Self-checking bench for the rate negotiation block
`timescale 1ns/10ps
module link_rate_negotiation_test;
   logic clk_i, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic enter_first_i = 1'b0, enter_retry_i = 1'b0, warm_reset_det_i = 1'b0;
   logic mute = 1'b0, slow = 1'b0, wb_ack_o, exit_valid_o, busy_o, tx_send_o, tx_done_i;
   logic rx_valid_i, phy_reconfig_o, tx_elec_idle_o, rx_term_o, tseq_prep_o, phy_done_i;
   logic [7:0] wb_adr_i = 8'h00, tx_msg_o, rx_msg_i;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic [2:0] exit_code_o;
   logic [1:0] phy_rate_o, cap = 2'h1;
   logic [31:0] tc[4] = '{32'h04, 32'h24, 32'h05, 32'h06};
   logic [2:0] te[4] = '{3'h2, 3'h3, 3'h2, 3'h4};
   int bad_count = 0, samples_checked = 0, cycles = 0, reconf_cycles = 0;

   link_rate_negotiation #(.TIMEOUT_CYC(200)) uut (.*);
   link_partner_model partner (.clk_i(clk_i), .rst_i(rst_i), .cap_i(cap), .mute_i(mute),
      .slow_i(slow), .tx_msg_i(tx_msg_o), .tx_send_i(tx_send_o), .tx_done_o(tx_done_i),
      .rx_msg_o(rx_msg_i), .rx_valid_o(rx_valid_i));

   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // PHY finishes one cycle after being asked
   always_ff @(posedge clk_i)
      phy_done_i <= phy_reconfig_o;

   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (phy_reconfig_o === 1'b1)
         reconf_cycles <= reconf_cycles + 1;
      if (cycles == 20000)
      begin
         bad_count++;
         wrap_up();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1);
      check(n, 32'h2);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb

   task automatic go(input logic [31:0] ctrl, input logic first, input logic [7:0] msg,
                     input logic [2:0] code, input logic [1:0] kick);
      wb(1'b1, link_rate_negotiation_pkg::CTRL_ADDR, ctrl);
      @(posedge clk_i);
      enter_first_i <= first;
      enter_retry_i <= !first;
      @(posedge clk_i);
      enter_first_i <= 1'b0;
      enter_retry_i <= 1'b0;
      #1;
      check(tx_msg_o, msg);
      if (kick == 2'h2)
      begin
         @(posedge clk_i);
         warm_reset_det_i <= 1'b1;
      end
      else if (kick != 2'h0)
         wb(1'b1, link_rate_negotiation_pkg::CTRL_ADDR, ctrl | (kick == 2'h1 ? 32'h100 : 32'h200));
      while (busy_o !== 1'b0)
      begin
         @(posedge clk_i);
         #1;
      end
      check(exit_code_o, code);
      @(posedge clk_i);
      warm_reset_det_i <= 1'b0;
      $display("test with control %h ended, exit %0d", ctrl, code);
   endtask : go

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : wrap_up

   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      check(tx_elec_idle_o, 1'b1);
      check(phy_rate_o, 2'h1);
      wb(1'b0, link_rate_negotiation_pkg::CTRL_ADDR, 32'h0);
      check(rd, 32'h4);
      wb(1'b0, 8'h10, 32'h0);
      check(rd, 32'h0);
      go(32'h44, 1'b1, 8'h04, 3'h1, 2'h0);
      check(reconf_cycles, 32'h0);
      go(32'h04, 1'b0, 8'h00, 3'h1, 2'h0);
      check(reconf_cycles != 0, 1'b1);
      check(phy_rate_o, 2'h0);
      slow <= 1'b1;
      cap <= 2'h0;
      go(32'h04, 1'b1, 8'h04, 3'h1, 2'h0);
      mute <= 1'b1;
      for (int i = 0; i < 4; i++)
         go(tc[i], 1'b1, 8'h04, te[i], 2'h0);
      go(32'h04, 1'b1, 8'h04, 3'h4, 2'h1);
      go(32'h04, 1'b1, 8'h04, 3'h2, 2'h3);
      go(32'h05, 1'b1, 8'h04, 3'h2, 2'h2);
      wrap_up();
   end
endmodule : link_rate_negotiation_test
